// file: pkg/sst_pkg.sv
package sst_pkg;
    // Command codes taken on a write with the select low
    localparam logic [7:0] CMD_SELF_TEST_READ = 8'h0F;
    localparam logic [7:0] CMD_SLEEP_IN       = 8'h10;
    localparam logic [7:0] CMD_SLEEP_OUT      = 8'h11;
    localparam logic [7:0] CMD_SOFT_RESET     = 8'h01;

    // Diagnostic byte layout
    localparam int         BIT_REG_LOAD_OK    = 7;
    localparam int         BIT_FUNC_OK        = 6;
    localparam logic [7:0] RESULT_RESET       = 8'h00;
    localparam logic [7:0] DUMMY_BYTE         = 8'h00;

    // Default configuration image reloaded on sleep exit
    localparam logic [7:0] CONFIG_DEFAULT     = 8'h00;

    // Self-test duration after sleep exit
    localparam int         CLOCK_HZ           = 40_000_000;
    localparam int         SELF_TEST_US       = 10;
    localparam int         SELF_TEST_CYCLES   =
        (SELF_TEST_US * (CLOCK_HZ / 1_000_000) > 0) ?
        SELF_TEST_US * (CLOCK_HZ / 1_000_000) : 1;
    localparam int         CNT_W              = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;

    typedef enum logic [1:0] {SST_ASLEEP, SST_TESTING, SST_AWAKE} sst_state_e;
    typedef enum logic [1:0] {SST_RD_IDLE, SST_RD_DUMMY, SST_RD_RESULT}
        sst_read_e;
endpackage

// file: rtl/sst_sleep_self_test.sv
`timescale 1ns/10ps
// Operation
// - Command 0F arms diagnostic byte read
// - First read dummy, second read result
// - D7 register load, D6 function, rest zero
// - Command 10 stops converter, oscillator, scan
// - Interface and frame memory survive sleep
// - Sleep-in while asleep is ignored
// - Sleep state after every reset
// - Command 11 wakes all internal blocks
// - Sleep-out while awake changes nothing
// - Sleep exit reloads default registers
// - Reload causes no visible artefact
// - Sleep exit runs self-test, latches result
module sst_sleep_self_test
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       data_command_select,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic [7:0] busDataIn,
    input  wire logic       registerLoadPass,
    input  wire logic       functionCheckPass,
    output logic      [7:0] busDataOut,
    output logic            busDataOe,
    output logic            sleepActive,
    output logic            converterEnable,
    output logic            oscillatorEnable,
    output logic            panelScanEnable,
    output logic            configReload,
    output logic      [7:0] configValue,
    output logic            selfTestBusy
);
    import sst_pkg::*;

    // State, strobe history, timer and latched bytes
    sst_state_e       state;
    sst_state_e       next_state;
    sst_read_e        readPhase;
    sst_read_e        next_readPhase;
    logic             writeDelay;
    logic             readDelay;
    logic [CNT_W-1:0] testCount;
    logic [CNT_W-1:0] next_testCount;
    logic [7:0]       result;
    logic [7:0]       next_result;
    wire  [7:0]       testByte;
    wire  [7:0]       next_busDataOut;
    logic             next_configReload;
    logic [7:0]       next_configValue;

    // Strobe edges; pins are taken as synchronous to the clock, so no
    // synchroniser is fitted: a host on another clock must add one in
    // front of this block
    wire writeRise = write_strobe_n & ~writeDelay;
    wire readRise  = read_strobe_n & ~readDelay;
    wire cmdTaken  = writeRise & ~data_command_select;
    wire dataRead  = readRise & data_command_select;

    // Command decode; unknown bytes fall through and only cancel a pending read.
    // Parameter bytes (select high) never reach this decode.
    wire isTestRd  = cmdTaken & (busDataIn == CMD_SELF_TEST_READ);
    wire isSleepIn = cmdTaken & (busDataIn == CMD_SLEEP_IN);
    wire isWake    = cmdTaken & (busDataIn == CMD_SLEEP_OUT);
    wire isSoftRst = cmdTaken & (busDataIn == CMD_SOFT_RESET);

    // Power state views; test end is the cycle the timer shows one
    wire asleep      = (state == SST_ASLEEP);
    wire testRunning = (state == SST_TESTING);
    wire testDone    = testRunning & (testCount == CNT_ONE);

    // Wake accepted only from sleep; soft reset in the same cycle wins.
    // Timer start is the cycle the state first turns to testing.
    wire wakeAccepted = isWake & asleep & ~isSoftRst;
    wire testStart    = (next_state == SST_TESTING) & ~testRunning;

    // Read path views
    wire readArmed  = (readPhase != SST_RD_IDLE);
    wire resultSlot = (readPhase == SST_RD_RESULT);

    // Power state; sleep-in while asleep and sleep-out while awake fall
    // through to hold, so nothing on the panel moves. Soft reset is
    // checked last so that it outranks every other transition.
    always_comb
    begin
        next_state = state;
        case (state)
            SST_ASLEEP:
            begin
                if (isWake)
                    next_state = SST_TESTING;
            end
            SST_TESTING:
            begin
                if (isSleepIn)
                    next_state = SST_ASLEEP;
                else if (testDone)
                    next_state = SST_AWAKE;
            end
            SST_AWAKE:
            begin
                if (isSleepIn)
                    next_state = SST_ASLEEP;
            end
            default:
                next_state = SST_ASLEEP;
        endcase
        if (isSoftRst)
            next_state = SST_ASLEEP;
    end

    // Diagnostic byte built bit by bit: two flags, all others held low
    // whatever the check inputs do
    genvar flagIdx;
    generate
        for (flagIdx = 0; flagIdx < $bits(testByte); flagIdx++)
        begin : g_test_byte
            if (flagIdx == BIT_REG_LOAD_OK)
            begin : g_reg_load
                assign testByte[flagIdx] = registerLoadPass;
            end
            else if (flagIdx == BIT_FUNC_OK)
            begin : g_func
                assign testByte[flagIdx] = functionCheckPass;
            end
            else
            begin : g_zero
                assign testByte[flagIdx] = RESULT_RESET[flagIdx];
            end
        end
    endgenerate

    // Result latched at end of test; soft reset clears it.
    // Check inputs matter only on the last test cycle.
    always_comb
    begin
        next_result = result;
        if (isSoftRst)
            next_result = RESULT_RESET;
        else if (testDone)
            next_result = testByte;
    end

    // Read sequence: dummy, result, then idle; 0F restarts it, other commands end it,
    // so a stray read after the result byte drives nothing
    always_comb
    begin
        next_readPhase = readPhase;
        case (readPhase)
            SST_RD_IDLE:
                next_readPhase = SST_RD_IDLE;
            SST_RD_DUMMY:
            begin
                if (dataRead)
                    next_readPhase = SST_RD_RESULT;
            end
            SST_RD_RESULT:
            begin
                if (dataRead)
                    next_readPhase = SST_RD_IDLE;
            end
            default:
                next_readPhase = SST_RD_IDLE;
        endcase
        if (cmdTaken)
            next_readPhase = isTestRd ? SST_RD_DUMMY : SST_RD_IDLE;
    end

    // Write strobe history, reset high like the idle pin, so that the
    // first cycle after reset never shows a false rising edge
    always_ff @(posedge clock)
    begin
        if (srst)
            writeDelay <= 1'h1;
        else
            writeDelay <= write_strobe_n;
    end

    // Read strobe history, same idle level as the pin; a read is
    // counted on the rising edge, when the host has taken the byte
    always_ff @(posedge clock)
    begin
        if (srst)
            readDelay <= 1'h1;
        else
            readDelay <= read_strobe_n;
    end

    // Power state; every reset lands in sleep
    always_ff @(posedge clock)
    begin
        if (srst)
            state <= SST_ASLEEP;
        else
            state <= next_state;
    end

    // Read sequence position; reset leaves nothing armed, so the
    // bus is not driven until a result read is asked for
    always_ff @(posedge clock)
    begin
        if (srst)
            readPhase <= SST_RD_IDLE;
        else
            readPhase <= next_readPhase;
    end

    // Diagnostic byte; flags stay low until a test has finished
    always_ff @(posedge clock)
    begin
        if (srst)
            result <= RESULT_RESET;
        else
            result <= next_result;
    end

    // Test timer: loaded on wake, counts down to one, then rests at
    // zero; a soft reset mid-test just lets it run out unused
    always_comb
    begin
        next_testCount = testCount;
        if (testStart)
            next_testCount = CNT_W'(SELF_TEST_CYCLES);
        else if (testCount != CNT_ZERO)
            next_testCount = testCount - CNT_ONE;
    end

    // Timer register; the width leaves room for a longer test
    // without touching the logic around it
    always_ff @(posedge clock)
    begin
        if (srst)
            testCount <= CNT_ZERO;
        else
            testCount <= next_testCount;
    end

    // Read data per bit: the result in its slot, the dummy elsewhere.
    // Registered, so the byte stands still while the strobe is low.
    genvar dataIdx;
    generate
        for (dataIdx = 0; dataIdx < $bits(busDataOut); dataIdx++)
        begin : g_read_data
            assign next_busDataOut[dataIdx] =
                resultSlot ? result[dataIdx] : DUMMY_BYTE[dataIdx];
        end
    endgenerate

    // Read data register; the port never gates on sleep, so the
    // diagnostic byte can be read while the panel is dark
    always_ff @(posedge clock)
    begin
        if (srst)
            busDataOut <= DUMMY_BYTE;
        else
            busDataOut <= next_busDataOut;
    end

    // Drive only in a read phase with the strobe low, so the host
    // owns the bus at all other times
    assign busDataOe = data_command_select & ~read_strobe_n
                     & readArmed;

    // Reload on sleep exit only, so an awake device never reloads
    // and a repeated sleep-out leaves the panel untouched
    assign next_configReload = wakeAccepted;
    assign next_configValue  = wakeAccepted ? CONFIG_DEFAULT : configValue;

    // One-cycle reload strobe toward the register file
    always_ff @(posedge clock)
    begin
        if (srst)
            configReload <= 1'h0;
        else
            configReload <= next_configReload;
    end

    // Default image; held between reloads
    always_ff @(posedge clock)
    begin
        if (srst)
            configValue <= CONFIG_DEFAULT;
        else
            configValue <= next_configValue;
    end

    // Analog and scan enables follow the power state directly; the
    // frame memory sits outside this block and is never touched,
    // so its contents survive any number of sleep cycles
    assign sleepActive      = asleep;
    assign converterEnable  = ~asleep;
    assign oscillatorEnable = ~asleep;
    assign panelScanEnable  = ~asleep;
    assign selfTestBusy     = testRunning;
endmodule

// file: testbench/sst_monitor.sv
`timescale 1ns/10ps
module sst_monitor
(
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       data_command_select,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic [7:0] busDataIn,
    input wire logic       busDataOe,
    input wire logic       sleepActive,
    input wire logic       converterEnable,
    input wire logic       configReload,
    input wire logic       selfTestBusy
);
    import sst_pkg::*;
    logic wrPrev;
    // A command counts once, on the rising edge of the write strobe
    always_ff @(posedge clock) wrPrev <= write_strobe_n;
    wire take = write_strobe_n & ~wrPrev & ~data_command_select;
    wire sIn = take && busDataIn == CMD_SLEEP_IN;
    wire sOut = take && busDataIn == CMD_SLEEP_OUT;
    int busyLen;
    // Length of the current busy stretch, in clock cycles
    always_ff @(posedge clock) busyLen <= selfTestBusy ? busyLen + 1 : 0;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_power_track: assert property (converterEnable == !sleepActive)
        else $error("power enable wrong");
    a_sleep_entry: assert property (sIn |-> ##[1:2] sleepActive)
        else $error("no sleep entry");
    a_sleep_repeat: assert property (sIn && sleepActive |=>
        (sleepActive && !selfTestBusy)[*2]) else $error("sleep-in acted");
    a_wake_start: assert property (sOut && sleepActive |->
        ##[1:2] (configReload && selfTestBusy)) else $error("no wake");
    a_wake_quiet: assert property (sOut && !sleepActive |=>
        (!configReload && !sleepActive)[*2]) else $error("wake acted");
    a_soft_sleep: assert property (take && busDataIn == CMD_SOFT_RESET
        |-> ##[1:2] sleepActive) else $error("no soft sleep");
    a_read_drive: assert property (busDataOe |->
        data_command_select && !read_strobe_n) else $error("stray drive");
    a_test_length: assert property ($rose(selfTestBusy) |->
        ##[398:402] !selfTestBusy) else $error("test length");
    a_test_span: assert property ($fell(selfTestBusy) &&
        !sleepActive |-> busyLen == SELF_TEST_CYCLES) else $error("test span");
endmodule
bind sst_sleep_self_test sst_monitor mon (.*);

// file: testbench/sst_host_model.sv
`timescale 1ns/10ps
// Host on the command bus; settle wait is scaled down from milliseconds
module sst_host_model
#(parameter int SETTLE = 200)
(
    input  wire logic       clock,
    input  wire logic [7:0] busDataOut,
    input  wire logic       busDataOe,
    output logic            data_command_select,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic      [7:0] busDataIn
);
    initial {data_command_select, write_strobe_n, read_strobe_n} = 3'h7;
    initial busDataIn = 8'h00;
    task automatic cmd(input logic [7:0] b);
        @(posedge clock) {data_command_select, write_strobe_n} <= 2'h0;
        busDataIn <= b;
        @(posedge clock) write_strobe_n <= 1'h1;
        // No video pins here; two frames fit in the settle wait
        @(posedge clock) busDataIn <= ~b; // Released bus shows no stale byte
        if (b == 8'h10 || b == 8'h11) repeat (SETTLE) @(posedge clock);
    endtask
    task automatic rd(output logic [7:0] v);
        @(posedge clock) {data_command_select, read_strobe_n} <= 2'h2;
        repeat (2) @(posedge clock);
        v = busDataOe ? busDataOut : 8'hXX;
        read_strobe_n <= 1'h1;
        @(posedge clock);
    endtask
endmodule

// file: testbench/tb_sleep_and_self_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb_sleep_and_self_test;
    import sst_pkg::*;
    logic clock = 1'h0, srst = 1'h1, registerLoadPass = 1'h0;
    logic functionCheckPass = 1'h0, data_command_select, write_strobe_n;
    logic read_strobe_n, busDataOe, sleepActive, converterEnable;
    logic oscillatorEnable, panelScanEnable, configReload, selfTestBusy;
    logic [7:0] busDataIn, busDataOut, configValue, v;
    int miscompares = 0, cmp_count = 0;
    always #12.5 clock = ~clock;
    sst_host_model #(.SETTLE(200)) host (.*);
    sst_sleep_self_test dut (.*);
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Read back the diagnostic byte, checking the dummy first
    task automatic get_result(input logic [7:0] e);
        host.cmd(CMD_SELF_TEST_READ);
        host.rd(v);
        `CHK(v, DUMMY_BYTE)
        host.rd(v);
        `CHK(v, e)
    endtask
    task automatic t_reset();
        `CHK({sleepActive, oscillatorEnable, panelScanEnable}, 3'h4)
        get_result(RESULT_RESET);
        $display("reset test done");
    endtask
    task automatic t_wake(input logic [1:0] p);
        @(posedge clock) {registerLoadPass, functionCheckPass} <= p;
        host.cmd(CMD_SLEEP_OUT);
        `CHK({sleepActive, oscillatorEnable, panelScanEnable}, 3'h3)
        for (int i = 0; i < 600 && selfTestBusy; i++) @(posedge clock);
        `CHK({selfTestBusy, configValue}, {1'b0, CONFIG_DEFAULT})
        get_result({p, 6'h00});
        host.cmd(CMD_SLEEP_OUT);
        `CHK({sleepActive, selfTestBusy}, 2'h0)
        host.cmd(CMD_SLEEP_IN);
        host.cmd(CMD_SLEEP_IN);
        `CHK({sleepActive, selfTestBusy}, 2'h2)
        $display("wake test done");
    endtask
    // Soft reset in mid-test must send the device back to sleep and stop the test
    task automatic t_soft();
        host.cmd(CMD_SLEEP_OUT);
        host.cmd(CMD_SOFT_RESET);
        repeat (2) @(posedge clock);
        `CHK({sleepActive, selfTestBusy}, 2'h2)
        get_result(RESULT_RESET);
        $display("soft reset test done");
    endtask
    // Hardware reset mid-test: back to sleep, stored flags cleared
    task automatic t_hw_reset();
        host.cmd(CMD_SLEEP_OUT);
        @(posedge clock) srst <= 1'h1;
        repeat (3) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        `CHK({sleepActive, selfTestBusy, configReload}, 3'h4)
        get_result(RESULT_RESET);
        $display("hardware reset test done");
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        t_reset();
        t_wake(2'h2);
        t_wake(2'h1);
        t_hw_reset();
        t_soft();
        finish_test();
    end
    // Whole run takes about 2500 cycles; allow over six times that
    initial
    begin
        #400_000;
        miscompares++;
        finish_test();
    end
endmodule
